/* core/bis_pkg.sv */
// bis_pkg: constants shared by the burner input supervision block
package bis_pkg;
	// clock and timebase
	localparam int CLK_NS = 4;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	// flame response times in milliseconds
	localparam int FLAME_RESP_MS = 1000;
	localparam logic [16:0] LOSS_BASE_MS = 17'(FLAME_RESP_MS - 1);
	localparam logic [15:0] FACTORY_FLAMEOUT_EXT_MS = 16'd1911;
	// optical detector test intervals in milliseconds
	localparam int OPT_TEST_SLOW_MS = 300000;
	localparam int OPT_TEST_FAST_MS = 5000;
	localparam logic [18:0] OPT_TEST_SLOW_CNT = 19'(OPT_TEST_SLOW_MS - 1);
	localparam logic [18:0] OPT_TEST_FAST_CNT = 19'(OPT_TEST_FAST_MS - 1);
	// proof contact modes
	localparam logic [1:0] PROOF_OFF = 2'h0;
	localparam logic [1:0] PROOF_CLOSED = 2'h1;
	localparam logic [1:0] PROOF_CHANGE = 2'h2;
	localparam logic [1:0] FACTORY_PROOF_MODE = PROOF_CLOSED;
	// lockout codes
	localparam logic [7:0] LOC_NONE = 8'h00;
	localparam logic [7:0] LOC_NO_FLAME = 8'h02;
	localparam logic [7:0] LOC_CHANNEL_DROP = 8'h07;
	localparam logic [7:0] LOC_PROOF = 8'h0e;
	localparam logic [7:0] LOW_GAS_LOCKOUT_CODE = 8'h14;
	localparam logic [7:0] LOC_HIGH_GAS = 8'h15;
	// phase shown during start prevention
	localparam logic [7:0] PHASE_PREVENT = 8'h5a;
	// restart limit: settings below this allow none
	localparam logic [2:0] RESTART_FIRST = 3'h2;
	// intensity scaling: percent = raw * 101 / 256
	localparam logic [14:0] PCT_MUL = 15'h0065;
	localparam int PCT_SHIFT = 8;
endpackage : bis_pkg

/* core/bis_sync.sv */
// bis_sync: two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bis_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// first stage, read only by the second
	logic [W-1:0] meta_ff;

	// two stages, reset to the safe open level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule : bis_sync

/* core/bis_tick.sv */
// bis_tick: common millisecond timebase for all supervision timers
`timescale 1ns/1ps
module bis_tick #(
	parameter int DIV = bis_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	output logic tick
);
	// divider counter, 32 bits covers any sane division
	logic [31:0] cnt_ff;

	// one-cycle tick every DIV clocks
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_ff == 32'(DIV - 1)) begin
			cnt_ff <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : bis_tick

/* core/bis_top.sv */
// bis_top: supervision of gas pressure, proof contact and flame inputs
// Summary of operation
// - setting 0: low gas gives shutdown, prevention
// - prevention: yellow lamp, loop on, phase 90
// - gas pressure back: restart automatically
// - setting 1: low gas locks out, code 20
// - window 0: evaluate from 30, not safety times
// - window 1: evaluate only in operation
// - proof mode 0: contact ignored entirely
// - proof mode 1: closed at startup, shutdown
// - proof mode 2: also open entering operation
// - wrong proof level locks out, code 14
// - proof mode defaults to 1
// - max gas watched from second interval
// - max gas opens: lock code 21
// - flame channels combined OR or AND
// - no extension: react within one second
// - extension adds to one second base
// - extension defaults to 1.911 seconds
// - flame-on response fixed, not adjustable
// - optical test every 5 min or 5 s
// - restart count limited by setting
// - flame intensity reported as percent
// - AND mode: channel drop locks, code 7
// - OR mode: no flame locks, code 2
`timescale 1ns/1ps
module bis_top #(
	parameter int TICK_DIV = bis_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic gas_min_ok,
	input wire logic gas_max_ok,
	input wire logic valve_closure_proof,
	input wire logic flame_ion,
	input wire logic flame_opt,
	input wire logic [7:0] ion_raw,
	input wire logic [7:0] opt_raw,
	input wire logic [7:0] seq_phase,
	input wire logic seq_from_30,
	input wire logic seq_safety1,
	input wire logic seq_safety2,
	input wire logic seq_operation,
	input wire logic second_interval_time,
	input wire logic seq_startup,
	input wire logic seq_shutdown,
	input wire logic seq_enter_op,
	input wire logic seq_safety_end,
	input wire logic seq_standby,
	input wire logic cfg_loss_resp,
	input wire logic cfg_eval_window,
	input wire logic cfg_gmax_en,
	input wire logic cfg_flame_and,
	input wire logic cfg_test_fast,
	input wire logic [2:0] cfg_restart_lim,
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_proof_mode,
	input wire logic [15:0] cfg_flameout_ext_ms,
	input wire logic unlock_req,
	output logic lockout,
	output logic [7:0] lockout_code,
	output logic start_prevent,
	output logic yellow_lamp,
	output logic safety_loop_on,
	output logic [7:0] phase_code,
	output logic safety_shutdown,
	output logic restart_req,
	output logic flame_ok,
	output logic opt_test_req,
	output logic [6:0] ion_pct,
	output logic [6:0] opt_pct
);
	// released reset copy
	logic rst_meta_ff;
	logic rst_sync_b;
	// synchronised pin levels
	logic [4:0] pins_s;
	logic gmin_s, gmax_s, proof_s, ion_s, opt_s;
	// millisecond tick
	logic tick;
	// held configuration
	logic [1:0] proof_mode_ff;
	logic [15:0] flameout_ext_ff;
	// lockout state
	logic lock_ff;
	logic [7:0] code_ff;
	logic fault_any;
	logic [7:0] fault_code;
	// start prevention state
	logic prevent_ff;
	// individual fault conditions
	logic gmin_eval, gmin_fail, gmax_fail, proof_fail;
	logic flame_any, flame_comb, flame_lost, loss_fire;
	logic no_flame_end, restart_ok;
	logic [16:0] loss_cnt_ff;
	logic [16:0] loss_lim;
	logic [18:0] opt_cnt_ff;
	logic [18:0] opt_lim;
	logic [2:0] restarts_ff;
	logic [2:0] restart_allow;
	logic [14:0] ion_prod, opt_prod;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_b <= rst_meta_ff;
		end
	end

	// switches and detectors come from the field, asynchronous
	bis_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.rst_b(rst_sync_b),
		.din({gas_min_ok, gas_max_ok, valve_closure_proof, flame_ion, flame_opt}),
		.dout(pins_s)
	);
	assign {gmin_s, gmax_s, proof_s, ion_s, opt_s} = pins_s;

	bis_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk(clk),
		.rst_b(rst_sync_b),
		.tick(tick)
	);

	// configuration held here so factory values exist after reset
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			proof_mode_ff <= bis_pkg::FACTORY_PROOF_MODE;
			flameout_ext_ff <= bis_pkg::FACTORY_FLAMEOUT_EXT_MS;
		end else if (cfg_wr) begin
			proof_mode_ff <= cfg_proof_mode;
			flameout_ext_ff <= cfg_flameout_ext_ms;
		end
	end

	// window 0 skips both safety times
	assign gmin_eval = cfg_eval_window ? seq_operation
		: (seq_from_30 && !seq_safety1 && !seq_safety2);
	assign gmin_fail = gmin_eval && !gmin_s && !prevent_ff;

	// max gas only from the second interval
	assign gmax_fail = cfg_gmax_en && second_interval_time && !gmax_s;

	// proof contact checks; mode 0 never looks at the input
	always_comb begin
		proof_fail = 1'b0;
		case (proof_mode_ff)
			bis_pkg::PROOF_OFF: begin
				proof_fail = 1'b0;
			end
			// closed check only, wire link passes
			bis_pkg::PROOF_CLOSED: begin
				proof_fail = (seq_startup || seq_shutdown) && !proof_s;
			end
			// must also open at operation entry
			bis_pkg::PROOF_CHANGE: begin
				proof_fail = ((seq_startup || seq_shutdown) && !proof_s) || (seq_enter_op && proof_s);
			end
			default: begin
				proof_fail = 1'b0;
			end
		endcase
	end

	assign flame_any = ion_s || opt_s;
	assign flame_comb = cfg_flame_and ? (ion_s && opt_s) : flame_any;
	assign flame_lost = seq_operation && !flame_comb;

	assign loss_lim = bis_pkg::LOSS_BASE_MS + {1'b0, flameout_ext_ff};

	// flame-out timer, counts milliseconds of lost flame; a used restart starts it over
	// so that one long loss cannot eat every restart in consecutive cycles
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			loss_cnt_ff <= 17'h0;
		end else if (!flame_lost || lock_ff || (!fault_any && !cfg_flame_and && loss_fire && restart_ok)) begin
			loss_cnt_ff <= 17'h0;
		end else if (tick && loss_cnt_ff < loss_lim) begin
			loss_cnt_ff <= loss_cnt_ff + 17'h1;
		end
	end
	assign loss_fire = flame_lost && loss_cnt_ff >= loss_lim;

	// no flame when the safety time ends
	assign no_flame_end = seq_safety_end && !flame_any;

	// settings 0 and 1 allow none
	assign restart_allow = (cfg_restart_lim >= bis_pkg::RESTART_FIRST)
		? (cfg_restart_lim - 3'h1) : 3'h0;
	assign restart_ok = restarts_ff < restart_allow;

	// fault priority: low gas, high gas, proof, flame
	always_comb begin
		fault_any = 1'b1;
		fault_code = bis_pkg::LOC_NONE;
		if (gmin_fail && cfg_loss_resp) begin
			fault_code = bis_pkg::LOW_GAS_LOCKOUT_CODE;
		end else if (gmax_fail) begin
			fault_code = bis_pkg::LOC_HIGH_GAS;
		end else if (proof_fail) begin
			fault_code = bis_pkg::LOC_PROOF;
		end else if (loss_fire && cfg_flame_and) begin
			fault_code = bis_pkg::LOC_CHANNEL_DROP;
		end else if ((loss_fire || no_flame_end) && !restart_ok) begin
			fault_code = bis_pkg::LOC_NO_FLAME;
		end else begin
			fault_any = 1'b0;
		end
	end

	// lockout latch; a new fault in the unlock cycle wins
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lock_ff <= 1'b0;
			code_ff <= bis_pkg::LOC_NONE;
		end else if (fault_any && !lock_ff) begin
			lock_ff <= 1'b1;
			code_ff <= fault_code;
		end else if (lock_ff && unlock_req && !fault_any) begin
			// only an unlock request clears it
			lock_ff <= 1'b0;
			code_ff <= bis_pkg::LOC_NONE;
		end
	end

	// start prevention on low gas with loss setting 0
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prevent_ff <= 1'b0;
		end else if (lock_ff) begin
			prevent_ff <= 1'b0;
		end else if (gmin_fail && !cfg_loss_resp) begin
			prevent_ff <= 1'b1;
		end else if (prevent_ff && gmin_s) begin
			prevent_ff <= 1'b0;
		end
	end

	// restart counter, cleared in standby; flame restarts use it
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			restarts_ff <= 3'h0;
		end else if (seq_standby || lock_ff) begin
			restarts_ff <= 3'h0;
		end else if (!fault_any && !cfg_flame_and && (loss_fire || no_flame_end) && restart_ok) begin
			restarts_ff <= restarts_ff + 3'h1;
		end else if (!fault_any && cfg_flame_and && no_flame_end && restart_ok) begin
			restarts_ff <= restarts_ff + 3'h1;
		end
	end

	// shutdown and restart pulses towards the sequencer
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			safety_shutdown <= 1'b0;
			restart_req <= 1'b0;
		end else begin
			// shutdown pulse on gas loss with loss setting 0 or restartable flame loss
			safety_shutdown <= !lock_ff && !fault_any
				&& ((gmin_fail && !cfg_loss_resp) || ((loss_fire || no_flame_end) && restart_ok));
			// restart when gas returns or a restart remains
			restart_req <= !lock_ff && !fault_any
				&& ((prevent_ff && gmin_s) || ((loss_fire || no_flame_end) && restart_ok));
		end
	end

	// status outputs, all registered
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lockout <= 1'b0;
			lockout_code <= bis_pkg::LOC_NONE;
			start_prevent <= 1'b0;
			yellow_lamp <= 1'b0;
			safety_loop_on <= 1'b0;
			phase_code <= 8'h00;
		end else begin
			lockout <= lock_ff;
			lockout_code <= code_ff;
			start_prevent <= prevent_ff;
			// lamp, loop and phase during prevention
			yellow_lamp <= prevent_ff;
			safety_loop_on <= !lock_ff;
			phase_code <= prevent_ff ? bis_pkg::PHASE_PREVENT : seq_phase;
		end
	end

	// flame-on path has no setting; synchroniser plus one register only
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			flame_ok <= 1'b0;
		end else begin
			flame_ok <= flame_comb;
		end
	end

	assign opt_lim = cfg_test_fast ? bis_pkg::OPT_TEST_FAST_CNT : bis_pkg::OPT_TEST_SLOW_CNT;

	// test timer runs in operation only; switching speed keeps the count, so one past the new limit requests at the next tick
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			opt_cnt_ff <= 19'h0;
			opt_test_req <= 1'b0;
		end else if (!seq_operation) begin
			opt_cnt_ff <= 19'h0;
			opt_test_req <= 1'b0;
		end else if (tick && opt_cnt_ff >= opt_lim) begin
			opt_cnt_ff <= 19'h0;
			opt_test_req <= 1'b1;
		end else begin
			opt_cnt_ff <= tick ? (opt_cnt_ff + 19'h1) : opt_cnt_ff;
			opt_test_req <= 1'b0;
		end
	end

	assign ion_prod = {7'h00, ion_raw} * bis_pkg::PCT_MUL;
	assign opt_prod = {7'h00, opt_raw} * bis_pkg::PCT_MUL;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ion_pct <= 7'h00;
			opt_pct <= 7'h00;
		end else begin
			ion_pct <= ion_prod[bis_pkg::PCT_SHIFT +: 7];
			opt_pct <= opt_prod[bis_pkg::PCT_SHIFT +: 7];
		end
	end

	// checks on the supervision behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_b);

	sequence s_locked_quiet;
		lock_ff && !unlock_req;
	endsequence

	sequence s_gas_back;
		prevent_ff && gmin_s && !lock_ff && !fault_any;
	endsequence

	a_lock_holds: assert property (s_locked_quiet |=> lock_ff && $stable(code_ff))
		else $error("lockout lost without unlock");
	a_low_gas_lock: assert property (gmin_fail && cfg_loss_resp && !lock_ff |=> lock_ff
		&& code_ff == bis_pkg::LOW_GAS_LOCKOUT_CODE ##1 lockout_code == bis_pkg::LOW_GAS_LOCKOUT_CODE)
		else $error("low gas did not lock with its code");
	a_prevent_phase: assert property (prevent_ff |=> phase_code == bis_pkg::PHASE_PREVENT && yellow_lamp
		&& safety_loop_on)
		else $error("prevention not shown");
	a_gas_restart: assert property (s_gas_back |=> !prevent_ff && restart_req)
		else $error("no restart after gas returned");
	a_gmax_window: assert property ($rose(lock_ff) && code_ff == bis_pkg::LOC_HIGH_GAS
		|-> $past(second_interval_time && cfg_gmax_en))
		else $error("max gas acted outside its window");
	a_proof_off: assert property ($rose(lock_ff) && code_ff == bis_pkg::LOC_PROOF
		|-> $past(proof_mode_ff) != bis_pkg::PROOF_OFF)
		else $error("proof lockout while ignored");
	a_loss_bound: assert property (loss_cnt_ff <= loss_lim || !flame_lost)
		else $error("flame-out timer passed its limit");
	a_restart_cap: assert property (restarts_ff <= restart_allow || seq_standby
		|| $changed(cfg_restart_lim))
		else $error("too many restarts");
	a_opt_period: assert property (seq_operation && $past(seq_operation) |-> opt_cnt_ff <= opt_lim
		|| $changed(cfg_test_fast))
		else $error("optical test interval overrun");
	a_and_drop: assert property (seq_operation && cfg_flame_and && loss_fire && !gmin_fail && !gmax_fail
		&& !proof_fail && !lock_ff |=> lock_ff && code_ff == bis_pkg::LOC_CHANNEL_DROP)
		else $error("channel drop did not lock with code 7");
endmodule : bis_top

/* verif/bis_far_side.sv */
// bis_far_side: behavioural pressure switches, proof contact and flame detectors
`timescale 1ns/1ps
module bis_far_side (
	input wire logic clk,
	input wire logic [4:0] want,
	output logic gas_min_ok,
	output logic gas_max_ok,
	output logic valve_closure_proof,
	output logic flame_ion,
	output logic flame_opt
);
	// contact levels, all closed and flames lit at power up
	logic [4:0] pins = 5'h1f;
	// contacts move a little after the edge, never on it, so the pins never race the block
	always @(posedge clk) begin
		pins <= #1 want;
	end
	// order: min gas, max gas, proof, ionisation, optical
	assign {gas_min_ok, gas_max_ok, valve_closure_proof, flame_ion, flame_opt} = pins;
endmodule : bis_far_side

/* verif/burner_input_supervision_test.sv */
// burner_input_supervision_test: self-checking bench for the supervision block
`timescale 1ns/1ps
module burner_input_supervision_test;
	localparam int DIV = 5; // short timebase: one tick every 5 clocks
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] want = 5'h1f; // commanded contact and flame levels
	logic gas_min_ok, gas_max_ok, valve_closure_proof, flame_ion, flame_opt;
	logic [7:0] ion_raw = 8'h00, opt_raw = 8'h00, seq_phase = 8'h00;
	logic seq_from_30 = 0, seq_safety1 = 0, seq_safety2 = 0, seq_operation = 0;
	logic second_interval_time = 0, seq_startup = 0, seq_shutdown = 0;
	logic seq_enter_op = 0, seq_safety_end = 0, seq_standby = 0;
	logic cfg_loss_resp = 0, cfg_eval_window = 0, cfg_gmax_en = 0, cfg_flame_and = 0;
	logic cfg_test_fast = 0, cfg_wr = 0, unlock_req = 0;
	logic [2:0] cfg_restart_lim = 3'h0;
	logic [1:0] cfg_proof_mode = 2'h1;
	logic [15:0] cfg_flameout_ext_ms = 16'h0000;
	logic lockout, start_prevent, yellow_lamp, safety_loop_on, safety_shutdown;
	logic restart_req, flame_ok, opt_test_req;
	logic [7:0] lockout_code, phase_code;
	logic [6:0] ion_pct, opt_pct;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 32'h5b094e7d;
	int n;
	int allow; // restarts the model permits for the drawn setting
	int q_ion[$];
	int q_opt[$];

	bis_far_side far (.clk, .want, .gas_min_ok, .gas_max_ok, .valve_closure_proof, .flame_ion, .flame_opt);

	bis_top #(.TICK_DIV(DIV)) uut (.clk, .rst_b, .gas_min_ok, .gas_max_ok, .valve_closure_proof,
		.flame_ion, .flame_opt, .ion_raw, .opt_raw, .seq_phase, .seq_from_30, .seq_safety1,
		.seq_safety2, .seq_operation, .second_interval_time, .seq_startup, .seq_shutdown,
		.seq_enter_op, .seq_safety_end, .seq_standby, .cfg_loss_resp, .cfg_eval_window,
		.cfg_gmax_en, .cfg_flame_and, .cfg_test_fast, .cfg_restart_lim, .cfg_wr, .cfg_proof_mode,
		.cfg_flameout_ext_ms, .unlock_req, .lockout, .lockout_code, .start_prevent, .yellow_lamp,
		.safety_loop_on, .phase_code, .safety_shutdown, .restart_req, .flame_ok, .opt_test_req,
		.ion_pct, .opt_pct);

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	// hang guard: the whole run needs well under 70000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 70000) begin
			mismatches++;
			final_report();
		end
	end

	// count every comparison, report any difference at once
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// move just past the edge so drives and samples never race it
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	function automatic logic pick(int s);
		case (s)
			0: return lockout;
			1: return restart_req;
			2: return start_prevent;
			3: return opt_test_req;
			default: return safety_shutdown;
		endcase
	endfunction : pick

	// bounded wait for one output; a pulse is caught in its own cycle
	task automatic wait_for(int s, int limit);
		n = 0;
		while (pick(s) !== 1'b1 && n < limit) begin
			step(1);
			n++;
		end
		check("wait", n < limit, 1);
	endtask : wait_for

	// lockout waits for an unlock request once inputs are healthy again
	task automatic unlock();
		want = 5'h1f;
		{seq_from_30, seq_safety1, seq_safety2, seq_operation, second_interval_time, seq_startup} = 6'h00;
		step(6);
		check("held", lockout, 1);
		unlock_req = 1'b1;
		step(1);
		unlock_req = 1'b0;
		step(2);
		check("unlocked", {lockout, lockout_code}, 9'h000);
	endtask : unlock

	// one safety-end pulse without flame: restart while the model allows one, else lockout
	task automatic end_pulse(logic exp_restart);
		seq_safety_end = 1'b1;
		step(1);
		seq_safety_end = 1'b0;
		check("end pulses", {safety_shutdown, restart_req}, {2{exp_restart}});
		step(1);
		check("end lock", lockout, !exp_restart);
	endtask : end_pulse

	// expected percentage from the raw reading, integer arithmetic only
	function automatic int pct(int raw);
		return raw * 101 / 256;
	endfunction : pct

	initial begin
		seq_phase = 8'($random(seed));
		step(12);
		rst_b = 1'b1;
		step(8);
		check("phase", phase_code, seq_phase);
		check("loop", safety_loop_on, 1);
		// factory proof mode: an open contact at startup locks
		seq_startup = 1'b1;
		want[2] = 1'b0;
		wait_for(0, 10);
		check("proof code", lockout_code, 8'h0e);
		unlock();
		// proof mode off and no flame-out extension
		cfg_proof_mode = 2'h0;
		cfg_wr = 1'b1;
		step(1);
		cfg_wr = 1'b0;
		seq_startup = 1'b1;
		want[2] = 1'b0;
		step(20);
		check("proof off", lockout, 0);
		// low gas ignored inside both safety times
		{seq_startup, seq_from_30, seq_safety1, seq_safety2} = 4'h7;
		want = 5'h0f;
		step(20);
		check("safety time", start_prevent, 0);
		{seq_safety1, seq_safety2} = 2'h0;
		wait_for(4, 10);
		step(1);
		check("prevent", {start_prevent, yellow_lamp, safety_loop_on, lockout, phase_code}, 12'he5a);
		want[4] = 1'b1;
		wait_for(1, 10);
		step(2);
		check("prevent over", start_prevent, 0);
		// window 1: only operation counts, then lockout on low gas
		{cfg_loss_resp, cfg_eval_window} = 2'h3;
		want[4] = 1'b0;
		step(20);
		check("window", lockout, 0);
		seq_operation = 1'b1;
		wait_for(0, 10);
		want[4] = 1'b1;
		step(20);
		check("low gas code", lockout_code, 8'h14);
		unlock();
		// max gas ignored before the second interval
		{cfg_gmax_en, seq_operation} = 2'h3;
		want[3] = 1'b0;
		step(20);
		check("early max", lockout, 0);
		second_interval_time = 1'b1;
		wait_for(0, 10);
		check("max code", lockout_code, 8'h15);
		unlock();
		// OR mode: one channel suffices, both lost locks within one second
		seq_operation = 1'b1;
		want[1] = 1'b0;
		step(6);
		check("or flame", flame_ok, 1);
		want[0] = 1'b0;
		step(900 * DIV);
		check("early loss", lockout, 0);
		wait_for(0, 110 * DIV);
		check("or code", lockout_code, 8'h02);
		unlock();
		// AND mode: one channel dropping locks with its own code
		{cfg_flame_and, seq_operation} = 2'h3;
		want[0] = 1'b0;
		step(6);
		check("and flame", flame_ok, 0);
		wait_for(0, 1100 * DIV);
		check("and code", lockout_code, 8'h07);
		unlock();
		// restarts on no flame at safety end, counted by an integer model
		allow = 1 + (($random(seed) & 32'h7fff) % 3);
		cfg_restart_lim = 3'(allow + 1);
		want[1:0] = 2'h0;
		step(4);
		end_pulse(1'b1);
		seq_standby = 1'b1;
		step(1);
		seq_standby = 1'b0;
		for (int k = 0; k <= allow; k++) begin
			end_pulse(k < allow);
		end
		check("restart code", lockout_code, 8'h02);
		cfg_restart_lim = 3'h0;
		unlock();
		// fast optical self test: first request within five seconds of operation
		{cfg_test_fast, seq_operation} = 2'h3;
		wait_for(3, 5010 * DIV);
		check("test interval", n > 4990 * DIV, 1);
		seq_operation = 1'b0;
		// proof mode 2: open contact accepted at entry, closed one locks
		cfg_proof_mode = 2'h2;
		cfg_wr = 1'b1;
		step(1);
		cfg_wr = 1'b0;
		want[2] = 1'b0;
		step(4);
		seq_enter_op = 1'b1;
		step(1);
		seq_enter_op = 1'b0;
		step(4);
		check("open at entry", lockout, 0);
		seq_shutdown = 1'b1;
		wait_for(0, 6);
		check("shutdown code", lockout_code, 8'h0e);
		seq_shutdown = 1'b0;
		unlock();
		seq_enter_op = 1'b1;
		step(1);
		seq_enter_op = 1'b0;
		wait_for(0, 6);
		check("closed at entry", lockout_code, 8'h0e);
		unlock();
		// reset in mid-run: outputs idle until the released copy reaches them
		rst_b = 1'b0;
		step(2);
		check("reset idle", {safety_loop_on, lockout, phase_code}, 10'h000);
		rst_b = 1'b1;
		step(2);
		check("release", safety_loop_on, 0);
		step(1);
		check("released", safety_loop_on, 1);
		step(3);
		// factory extension: OR loss locks only after one plus 1.911 seconds
		cfg_flame_and = 1'b0;
		seq_operation = 1'b1;
		want[1:0] = 2'h0;
		step(2850 * DIV);
		check("factory ext", lockout, 0);
		wait_for(0, 80 * DIV);
		check("ext code", lockout_code, 8'h02);
		unlock();
		// intensity readback against a one-cycle queue model
		repeat (24) begin
			ion_raw = 8'($random(seed));
			opt_raw = 8'($random(seed));
			q_ion.push_back(pct(ion_raw));
			q_opt.push_back(pct(opt_raw));
			step(1);
			check("ion pct", ion_pct, q_ion.pop_front());
			check("opt pct", opt_pct, q_opt.pop_front());
		end
		final_report();
	end
endmodule : burner_input_supervision_test
